// >>> fcsr_map.svh
// Constants of the flash configuration/status register command block.
// Assumes an SPI mode 0 host; included by bare name.
//
// Summary of operation
// - Opcode 15h shifts the configuration register out on the serial output.
// - Configuration reads are answered at any time, even while busy.
// - Bit 7 picks hold or reset pin role; quad enable makes it data.
// - Drive field: 00 60%, 01 100%, 10 default 140%, 11 40%.
// - Page field: 00 256, 01 512, 10 1024 bytes, 11 reserved.
// - Page field 00 or 11 wraps buffer load address at 256 bytes, 01 at 512, 10 at 1024.
// - Page erase 81h erases two pages at 01, four pages at 10.
// - Page, dummy and pattern bits volatile; role, drive, scheme bits kept.
// - Scheme bit picks block-protect or lock bits; lock bits reset to one.
// - Dummy bit gives BBh 4 or 8 and EBh 6 or 10 clocks.
// - Pattern enable drives 00110100 on every line in double-rate dummy cycles.
// - Pattern enable is written volatile by configuration write 11h.
// - Status write ignored unless write-enable latch was set earlier.
// - Status write never changes status bits 15, 10, 1 and 0.
// - Status write taken only when select rises after 8 or 16 data bits.
// - Eight-bit status write clears complement, quad enable and upper protect bit.
// - Accepted write starts timed cycle; busy then, clears busy and latch after.
// - Status reads stay answered during the timed write cycle.
// - Status write refused wholly while hardware protection is in force.
// - Status write opcodes 01h and 31h; option D rejects 31h.
// - Protect bits 01 with protect pin low lock both registers.
// - Opcode 05h returns status bits 7..0, 35h returns bits 15..8.
// - Configuration write needs write-enable, one byte, then runs a timed cycle.
`ifndef FCSR_MAP_SVH
`define FCSR_MAP_SVH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define FCSR_OP_WRITE_EN 8'h06
`define FCSR_OP_RDSR_LO 8'h05
`define FCSR_OP_RDSR_HI 8'h35
`define FCSR_OP_CFG_RD 8'h15
`define FCSR_OP_SR_WR 8'h01
`define FCSR_OP_SR_WR_ALT 8'h31
`define FCSR_OP_CFG_WR 8'h11
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define FCSR_CFG_RST 8'h40
`define FCSR_CFG_VOL 8'h1b
`define FCSR_SR_RST 16'h0000
`define FCSR_SR_KEEP 16'h8403
`define FCSR_SR_CLR8 16'h4300
`define FCSR_SR_OTP 16'h3800
`define FCSR_SR_QUAD 9
`define FCSR_SR_PROT_HI 8
`define FCSR_SR_PROT_LO 7
`define FCSR_LOCK_RST 8'hff
`define FCSR_LP_PATTERN 8'h34
// ----------------------------------------
// Counts and timing
// ----------------------------------------
`define FCSR_BITS_OP 5'd8
`define FCSR_BITS_W8 5'd16
`define FCSR_BITS_W16 5'd24
`define FCSR_DUMMY_BB0 4'h4
`define FCSR_DUMMY_BB1 4'h8
`define FCSR_DUMMY_EB0 4'h6
`define FCSR_DUMMY_EB1 4'ha
`define FCSR_CLK_MHZ 10
`define FCSR_WRITE_US 5
`endif

// >>> fcsr_pkg.sv
// Types of the flash configuration/status register command block.
// Assumes fcsr_map.svh for all numeric constants.
package fcsr_pkg;
   typedef enum logic [1:0] {FCSR_PIN_HOLD, FCSR_PIN_RESET, FCSR_PIN_DATA} fcsr_pin_role_t;
   typedef enum logic [2:0] {FCSR_IDLE, FCSR_OPCODE, FCSR_READ, FCSR_WDATA, FCSR_SKIP}
      fcsr_state_t;
   typedef struct packed {
      logic pin_reset;
      logic [1:0] drive;
      logic [1:0] page_size;
      logic scheme;
      logic dummy_sel;
      logic pattern_en;
   } fcsr_cfg_t;
   typedef struct packed {
      logic cs_b;
      logic sclk;
      logic si;
      logic wp_b;
      logic opt_d;
   } fcsr_pins_t;
endpackage

// >>> fcsr_wcycle.sv
// Self-timed write cycle timer.
// Assumes start is a one-cycle pulse on clk.
`timescale 1ns/1ns
module fcsr_wcycle #(
   parameter int CYCLES = 50
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic start,
   output logic busy,
   output logic done
);
   logic [15:0] count;
   wire last = (count == 16'h0001);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= 16'h0000;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= busy & last;
         if (start && !busy) begin
            count <= 16'(CYCLES);
            busy <= 1'b1;
         end else if (busy) begin
            count <= count - 16'h0001;
            busy <= !last;
         end
      end
   end
endmodule // fcsr_wcycle

// >>> fcsr_top.sv
// Command logic for configuration reads and status/configuration writes.
// Assumes SPI mode 0 pins from outside the clk domain; other inputs on clk.
`include "fcsr_map.svh"
`timescale 1ns/1ns
module fcsr_top #(
   parameter int WRITE_CYCLES = `FCSR_WRITE_US * `FCSR_CLK_MHZ
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Serial link pins
   input wire logic cs_b,
   input wire logic sclk,
   input wire logic si,
   output logic so,
   output logic so_oe,
   // Protect pin and ordering strap
   input wire logic wp_b,
   input wire logic opt_d,
   // Core side
   input wire logic soft_reset,
   input wire logic array_busy,
   input wire logic ep_fail,
   input wire logic buf_load,
   input wire logic dtr_dummy,
   input wire logic [2:0] dummy_idx,
   // Configuration effects
   output fcsr_pkg::fcsr_pin_role_t pin_role,
   output logic [1:0] drive_strength,
   output logic [10:0] page_bytes,
   output logic [2:0] erase_pages,
   output logic [9:0] buf_ptr,
   output logic scheme_locks,
   output logic [7:0] lock_bits,
   output logic [3:0] dummy_bb,
   output logic [3:0] dummy_eb,
   output logic [3:0] lp_io,
   output logic lp_oe,
   output logic [15:0] status_out
);
   // ----------------------------------------
   // Decode functions
   // ----------------------------------------
   function automatic fcsr_pkg::fcsr_state_t decode(input logic [7:0] op, input logic optd);
      case (op)
         `FCSR_OP_RDSR_LO, `FCSR_OP_RDSR_HI, `FCSR_OP_CFG_RD: decode = fcsr_pkg::FCSR_READ;
         `FCSR_OP_SR_WR, `FCSR_OP_CFG_WR: decode = fcsr_pkg::FCSR_WDATA;
         `FCSR_OP_SR_WR_ALT: decode = optd ? fcsr_pkg::FCSR_SKIP : fcsr_pkg::FCSR_WDATA;
         default: decode = fcsr_pkg::FCSR_SKIP;
      endcase
   endfunction
   function automatic logic [9:0] page_mask(input logic [1:0] ps);
      case (ps)
         2'b01: page_mask = 10'h1ff;
         2'b10: page_mask = 10'h3ff;
         default: page_mask = 10'h0ff;
      endcase
   endfunction
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   fcsr_pkg::fcsr_pins_t pin_s1, pin_s2, pin_s3;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1 <= 5'b1_0011;
         pin_s2 <= 5'b1_0011;
         pin_s3 <= 5'b1_0011;
      end else begin
         pin_s1 <= '{cs_b, sclk, si, wp_b, opt_d};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end
   wire cs_fall = !pin_s2.cs_b && pin_s3.cs_b;
   wire cs_rise = pin_s2.cs_b && !pin_s3.cs_b;
   wire sclk_rise = pin_s2.sclk && !pin_s3.sclk && !pin_s2.cs_b;
   wire sclk_fall = !pin_s2.sclk && pin_s3.sclk && !pin_s2.cs_b;
   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   fcsr_pkg::fcsr_state_t state;
   fcsr_pkg::fcsr_cfg_t cfg;
   logic [15:0] sr;
   logic wr_latch;
   logic [4:0] bitcnt;
   logic [7:0] shreg, op, byte0, byte1, tx;
   logic [2:0] txcnt;
   logic wc_busy, wc_done;
   // ----------------------------------------
   // Command decode and acceptance
   // ----------------------------------------
   wire [7:0] rx_byte = {shreg[6:0], pin_s2.si};
   wire op_done = sclk_rise && (state == fcsr_pkg::FCSR_OPCODE) && (bitcnt == 5'd7);
   wire busy_flag = wc_busy | array_busy;
   wire [15:0] status_view = {1'b0, sr[14:11], ep_fail, sr[9:2], wr_latch, busy_flag};
   wire hw_locked = sr[`FCSR_SR_PROT_HI] | (sr[`FCSR_SR_PROT_LO] & !pin_s2.wp_b);
   wire op_cfg_wr = (op == `FCSR_OP_CFG_WR);
   wire short_wr = (bitcnt == `FCSR_BITS_W8);
   wire long_wr = (bitcnt == `FCSR_BITS_W16) && !op_cfg_wr;
   wire wr_try = cs_rise && (state == fcsr_pkg::FCSR_WDATA) && (short_wr || long_wr);
   wire wr_start = wr_try && wr_latch && !hw_locked && !busy_flag;
   wire sr_start = wr_start && !op_cfg_wr;
   wire cr_start = wr_start && op_cfg_wr;
   wire latch_set = cs_rise && (state == fcsr_pkg::FCSR_SKIP) && (op == `FCSR_OP_WRITE_EN)
      && (bitcnt == `FCSR_BITS_OP);
   wire [15:0] clr8_mask = `FCSR_SR_CLR8;
   wire [7:0] lp_pattern = `FCSR_LP_PATTERN;
   // Low byte first, upper byte partly cleared on a short write
   wire [15:0] wr_word = short_wr ? {sr[15:8] & ~clr8_mask[15:8], byte0}
      : {byte1, byte0};
   // Lock bits are one-time: written ones stay set
   wire [15:0] next_sr = (sr & (`FCSR_SR_KEEP | `FCSR_SR_OTP))
      | (wr_word & ~`FCSR_SR_KEEP);
   wire [7:0] next_cfg_vol = (cfg & ~`FCSR_CFG_VOL) | (`FCSR_CFG_RST & `FCSR_CFG_VOL);
   wire [7:0] live_byte = (op == `FCSR_OP_CFG_RD) ? cfg
      : (op == `FCSR_OP_RDSR_HI) ? status_view[15:8] : status_view[7:0];
   wire [9:0] pmask = page_mask(cfg.page_size);
   wire [9:0] next_ptr = (buf_ptr & ~pmask) | ((buf_ptr + 10'h001) & pmask);
   // ----------------------------------------
   // Serial front end
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= fcsr_pkg::FCSR_IDLE;
         bitcnt <= 5'd0;
         shreg <= 8'h00;
         op <= 8'h00;
         byte0 <= 8'h00;
         byte1 <= 8'h00;
      end else if (pin_s2.cs_b) begin
         state <= fcsr_pkg::FCSR_IDLE;
      end else if (cs_fall) begin
         state <= fcsr_pkg::FCSR_OPCODE;
         bitcnt <= 5'd0;
      end else if (sclk_rise && state != fcsr_pkg::FCSR_IDLE) begin
         shreg <= rx_byte;
         bitcnt <= (bitcnt == 5'd31) ? bitcnt : bitcnt + 5'd1;
         if (op_done) begin
            op <= rx_byte;
            state <= decode(rx_byte, pin_s2.opt_d);
         end
         if (state == fcsr_pkg::FCSR_WDATA && bitcnt == 5'd15) begin
            byte0 <= rx_byte;
         end
         if (state == fcsr_pkg::FCSR_WDATA && bitcnt == 5'd23) begin
            byte1 <= rx_byte;
         end
      end
   end
   // Output shifts on falling clock edges; each byte reloads live so busy polls refresh
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx <= 8'h00;
         txcnt <= 3'd0;
         so <= 1'b0;
         so_oe <= 1'b0;
      end else if (cs_fall || pin_s2.cs_b) begin
         txcnt <= 3'd0;
         so_oe <= 1'b0;
      end else if (sclk_fall && state == fcsr_pkg::FCSR_READ) begin
         so <= (txcnt == 3'd0) ? live_byte[7] : tx[7];
         tx <= (txcnt == 3'd0) ? {live_byte[6:0], 1'b0} : {tx[6:0], 1'b0};
         txcnt <= txcnt + 3'd1;
         so_oe <= 1'b1;
      end
   end
   // ----------------------------------------
   // Register file
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sr <= `FCSR_SR_RST;
         cfg <= `FCSR_CFG_RST;
         wr_latch <= 1'b0;
      end else begin
         if (sr_start) begin
            sr <= next_sr;
         end
         if (cr_start) begin
            cfg <= byte0;
         end else if (soft_reset) begin
            cfg <= next_cfg_vol;
         end
         if (wc_done) begin
            wr_latch <= 1'b0;
         end
         if (latch_set) begin
            wr_latch <= 1'b1;
         end
      end
   end
   fcsr_wcycle #(
      .CYCLES(WRITE_CYCLES)
   ) u_wcycle (
      .clk(clk),
      .rst_b(rst_b),
      .start(wr_start),
      .busy(wc_busy),
      .done(wc_done)
   );
   // ----------------------------------------
   // Configuration effects
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_role <= fcsr_pkg::FCSR_PIN_HOLD;
         drive_strength <= 2'b10;
         page_bytes <= 11'h100;
         erase_pages <= 3'd1;
         buf_ptr <= 10'h000;
         scheme_locks <= 1'b0;
         lock_bits <= `FCSR_LOCK_RST;
         dummy_bb <= `FCSR_DUMMY_BB0;
         dummy_eb <= `FCSR_DUMMY_EB0;
         lp_io <= 4'h0;
         lp_oe <= 1'b0;
         status_out <= `FCSR_SR_RST;
      end else begin
         pin_role <= sr[`FCSR_SR_QUAD] ? fcsr_pkg::FCSR_PIN_DATA
            : cfg.pin_reset ? fcsr_pkg::FCSR_PIN_RESET : fcsr_pkg::FCSR_PIN_HOLD;
         drive_strength <= cfg.drive;
         page_bytes <= {1'b0, pmask} + 11'h001;
         erase_pages <= (cfg.page_size == 2'b01) ? 3'd2
            : (cfg.page_size == 2'b10) ? 3'd4 : 3'd1;
         buf_ptr <= cs_fall ? 10'h000 : buf_load ? next_ptr : buf_ptr;
         scheme_locks <= cfg.scheme;
         if (soft_reset) begin
            lock_bits <= `FCSR_LOCK_RST;
         end
         dummy_bb <= cfg.dummy_sel ? `FCSR_DUMMY_BB1 : `FCSR_DUMMY_BB0;
         dummy_eb <= cfg.dummy_sel ? `FCSR_DUMMY_EB1 : `FCSR_DUMMY_EB0;
         lp_io <= {4{cfg.pattern_en & dtr_dummy & lp_pattern[3'd7 - dummy_idx]}};
         lp_oe <= cfg.pattern_en & dtr_dummy;
         status_out <= status_view;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_oe_drops;
      cs_rise |=> !so_oe [*2];
   endproperty
   a_oe_drops: assert property (p_oe_drops) else $error("so_oe held after select rise");
   property p_needs_latch;
      wr_start |-> wr_latch && !hw_locked;
   endproperty
   a_needs_latch: assert property (p_needs_latch) else $error("write without latch");
   property p_keep_bits;
      sr_start |=> sr[15] == $past(sr[15]) && sr[10] == $past(sr[10]);
   endproperty
   a_keep_bits: assert property (p_keep_bits) else $error("kept status bit changed");
   property p_bitcount;
      cs_rise && state == fcsr_pkg::FCSR_WDATA && bitcnt != 5'd16 && bitcnt != 5'd24
         |-> !wr_start;
   endproperty
   a_bitcount: assert property (p_bitcount) else $error("odd bit count accepted");
   property p_short_clear;
      sr_start && short_wr |=> !sr[14] && !sr[9] && !sr[8];
   endproperty
   a_short_clear: assert property (p_short_clear) else $error("short write kept bits");
   property p_busy_run;
      wr_start |=> ##1 (status_view[0] && wc_busy) [*8];
   endproperty
   a_busy_run: assert property (p_busy_run) else $error("busy not held");
   property p_done_clear;
      wc_done && !latch_set |=> !wr_latch && !wc_busy;
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("latch kept after cycle");
   property p_opt_d;
      wr_start |-> !(op == `FCSR_OP_SR_WR_ALT && pin_s2.opt_d);
   endproperty
   a_opt_d: assert property (p_opt_d) else $error("alternate opcode ran under option");
   property p_dummy;
      cr_start |-> ##2 dummy_eb == ($past(byte0[1], 2) ? 4'ha : 4'h6);
   endproperty
   a_dummy: assert property (p_dummy) else $error("dummy count wrong");
   property p_wrap;
      buf_load && !cs_fall && cfg.page_size == 2'b00 && buf_ptr[7:0] == 8'hff
         |=> buf_ptr[7:0] == 8'h00 && $stable(buf_ptr[9:8]);
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap at 256");
   property p_no_pattern;
      !cfg.pattern_en |=> !lp_oe && lp_io == 4'h0;
   endproperty
   a_no_pattern: assert property (p_no_pattern) else $error("pattern while disabled");
   c_short: cover property (sr_start && short_wr);
   c_long: cover property (sr_start && long_wr);
   c_cfg: cover property (cr_start);
   c_poll: cover property (wc_busy && so_oe && op == `FCSR_OP_RDSR_LO);
endmodule // fcsr_top

// >>> fcsr_host.sv
// Host model of the serial link: SPI mode 0 frames on cs_b, sclk and si.
// Assumes the caller starts each frame just after a falling clk edge.
`timescale 1ns/1ns
module fcsr_host (
   // Clock
   input wire logic clk,
   // Link pins
   output logic cs_b,
   output logic sclk,
   output logic si,
   input wire logic so
);
   initial begin
      cs_b = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   // ----------------------------------------
   // Frame
   // ----------------------------------------
   // Four clk per half period gives an 800 ns sclk
   task automatic frame(input logic [7:0] op, input logic [15:0] wd, input int nw,
                        input int nr, output logic [15:0] rd);
      logic [23:0] sh;
      sh = {op, wd};
      rd = 16'h0000;
      cs_b = 1'b0;
      repeat (4) @(negedge clk);
      for (int k = 0; k < 8 + nw + nr; k++) begin
         // Released data line toggles, never holds a stale bit
         si = (k < 8 + nw) ? sh[23 - k] : ~si;
         repeat (4) @(negedge clk);
         sclk = 1'b1;
         if (k >= 8 + nw) rd = {rd[14:0], so};
         repeat (4) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (4) @(negedge clk);
      cs_b = 1'b1;
      si = ~si;
      repeat (8) @(negedge clk);
   endtask
endmodule // fcsr_host

// >>> fcsr_top_tb_top.sv
// Self-checking bench of the configuration and status command logic.
// Assumes fcsr_host on the link; core-side inputs driven on falling clk.
`timescale 1ns/1ns
module fcsr_top_tb_top;
   // Long write cycle so one status poll lands inside it
   localparam int WRITE_LEN = 200;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cs_b, sclk, si, so, so_oe, scheme_locks, lp_oe;
   logic wp_b = 1'b1, opt_d = 1'b0, soft_reset = 1'b0, array_busy = 1'b0;
   logic ep_fail = 1'b0, buf_load = 1'b0, dtr_dummy = 1'b0;
   logic [2:0] dummy_idx = 3'h0;
   fcsr_pkg::fcsr_pin_role_t pin_role;
   logic [1:0] drive_strength;
   logic [10:0] page_bytes;
   logic [2:0] erase_pages;
   logic [9:0] buf_ptr;
   logic [7:0] lock_bits, c, cfg_m;
   logic [3:0] dummy_bb, dummy_eb, lp_io;
   logic [15:0] status_out, sr_m, r, v;
   logic [7:0] t_op [10] = '{8'h01, 8'h01, 8'h01, 8'h31, 8'h31, 8'h01, 8'h01, 8'h01, 8'h11, 8'h01};
   int t_nw [10] = '{16, 8, 12, 16, 8, 16, 16, 16, 8, 16};
   // Control: opt_d, protect pin low, array busy
   logic [2:0] t_ctl [10] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h0, 3'h1, 3'h0, 3'h2, 3'h2, 3'h0};
   logic [15:0] t_set [10] = '{16'h4200, 0, 0, 0, 0, 0, 16'h0080, 0, 0, 0};
   integer seed = 47;
   int num_errors = 0, n_checks = 0, cycles = 0, n;
   always #50 clk = ~clk;
   fcsr_host host (.clk(clk), .cs_b(cs_b), .sclk(sclk), .si(si), .so(so));
   fcsr_top #(.WRITE_CYCLES(WRITE_LEN)) dut (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk),
      .si(si), .so(so), .so_oe(so_oe), .wp_b(wp_b), .opt_d(opt_d), .soft_reset(soft_reset),
      .array_busy(array_busy), .ep_fail(ep_fail), .buf_load(buf_load), .dtr_dummy(dtr_dummy),
      .dummy_idx(dummy_idx), .pin_role(pin_role), .drive_strength(drive_strength),
      .page_bytes(page_bytes), .erase_pages(erase_pages), .buf_ptr(buf_ptr),
      .scheme_locks(scheme_locks), .lock_bits(lock_bits), .dummy_bb(dummy_bb),
      .dummy_eb(dummy_eb), .lp_io(lp_io), .lp_oe(lp_oe), .status_out(status_out));
   // ----------------------------------------
   // Checks and helpers
   // ----------------------------------------
   task automatic results();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp, input string m);
      chk_reg(got, exp, {"pin ", m});
   endtask
   task automatic rd(input logic [7:0] op, input logic [7:0] exp, input string m);
      host.frame(op, 16'h0000, 0, 8, r);
      chk_reg(16'(r[7:0]), 16'(exp), m);
   endtask
   // Data arrives in send order: first byte in the top half
   function automatic logic [15:0] sr_next(input logic [15:0] o, input logic [15:0] d,
                                           input bit w16);
      logic [15:0] x;
      x = w16 ? {d[7:0], d[15:8]} : {o[15:8] & 8'hbc, d[15:8]};
      return (o & 16'h8403) | (x & 16'h7bfc);
   endfunction
   task automatic chk_outs();
      logic [1:0] pg;
      pg = cfg_m[4:3];
      chk_pin(16'(pin_role), sr_m[9] ? 16'h0002 : 16'(cfg_m[7]), "role");
      chk_pin(16'(drive_strength), 16'(cfg_m[6:5]), "drive");
      chk_pin(16'(page_bytes), pg[0] ? 16'h0200 : pg[1] ? 16'h0400 : 16'h0100, "page");
      chk_pin(16'(erase_pages), pg[0] ? 16'h0002 : pg[1] ? 16'h0004 : 16'h0001, "erase");
      chk_pin(16'(scheme_locks), 16'(cfg_m[2]), "scheme");
      chk_pin(16'({dummy_bb, dummy_eb}), cfg_m[1] ? 16'h008a : 16'h0046, "dummy");
      chk_pin(16'(lp_oe), 16'h0000, "lp idle");
      chk_pin(16'(so_oe), 16'h0000, "oe idle");
   endtask
   task automatic wr(input logic [7:0] op, input logic [15:0] wd, input int nw, input bit ok);
      int k;
      host.frame(8'h06, 16'h0000, 0, 0, r);
      host.frame(op, wd, nw, 0, r);
      k = 0;
      if (ok) begin
         host.frame(8'h05, 16'h0000, 0, 8, r);
         chk_reg(16'(r[1:0]), 16'h0003, "poll");
         while (status_out[0] !== 1'b0 && k < 1000) begin
            @(negedge clk);
            k++;
         end
         repeat (2) @(negedge clk);
         chk_pin(status_out, sr_m, "after cycle");
      end
      else repeat (8) @(negedge clk);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         results();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      sr_m = 16'h0000;
      cfg_m = 8'h40;
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      chk_outs();
      chk_pin(16'(lock_bits), 16'h00ff, "locks");
      rd(8'h15, 8'h40, "cfg reset");
      rd(8'h05, 8'h00, "sr lo");
      host.frame(8'h11, 16'h9c00, 8, 0, r);
      rd(8'h15, 8'h40, "no latch");
      for (int i = 0; i < 4; i++) begin
         c = (8'($random(seed)) & 8'h84) | {1'b0, 2'(i), 2'(i % 3), 1'b0, 1'(i >> 1), 1'(i)};
         wr(8'h11, {c, 8'h00}, 12, 1'b0);
         rd(8'h15, cfg_m, "write_config_command count");
         cfg_m = c;
         wr(8'h11, {c, 8'h00}, 8, 1'b1);
         rd(8'h15, cfg_m, "cfg");
         chk_outs();
         for (int j = 0; j < 8; j++) begin
            dtr_dummy = 1'b1;
            dummy_idx = 3'(j);
            repeat (2) @(negedge clk);
            chk_pin(16'({lp_oe, lp_io}), c[0] ? 16'({1'b1, {4{n8(j)}}}) : 16'h0000,
                    "pattern");
         end
         dtr_dummy = 1'b0;
         if (i < 2) begin
            n = 257 + ($random(seed) & 127);
            buf_load = 1'b1;
            repeat (n) @(negedge clk);
            buf_load = 1'b0;
            @(negedge clk);
            chk_pin(16'(buf_ptr), 16'(i == 0 ? n % 256 : n), "buf");
         end
      end
      soft_reset = 1'b1;
      @(negedge clk);
      soft_reset = 1'b0;
      cfg_m = cfg_m & 8'he4;
      repeat (2) @(negedge clk);
      chk_pin(16'(lock_bits), 16'h00ff, "soft locks");
      rd(8'h15, cfg_m, "soft cfg");
      for (int j = 0; j < 10; j++) begin
         logic ok;
         v = (16'($random(seed)) & 16'h427c) | t_set[j];
         opt_d = t_ctl[j][2];
         wp_b = ~t_ctl[j][1];
         array_busy = t_ctl[j][0];
         repeat (4) @(negedge clk);
         // The configuration case in the table is always locked
         ok = !(array_busy || sr_m[8] || (sr_m[7] && !wp_b)) && t_op[j] != 8'h11;
         ok = ok && (t_nw[j] == 8 || t_nw[j] == 16) && !(t_op[j] == 8'h31 && opt_d);
         if (ok) sr_m = sr_next(sr_m, {v[7:0], v[15:8]}, t_nw[j] == 16);
         wr(t_op[j], {v[7:0], v[15:8]}, t_nw[j], ok);
         rd(8'h15, cfg_m, "cfg any time");
         if (!ok) chk_pin(16'(status_out[15:2]), 16'(sr_m[15:2]), "refused");
         rd(8'h35, sr_m[15:8], "sr hi");
         chk_outs();
      end
      array_busy = 1'b0;
      results();
   end
   function automatic logic n8(input int j);
      logic [7:0] p;
      p = 8'h34;
      return p[7 - j];
   endfunction
endmodule // fcsr_top_tb_top
